/* src/sdc_bank_ctrl.sv */
// Per-bank row state: idle, active with an open row, or precharging.
// Assumes activate requests come only from the decoder's checked path.
`timescale 1ns/1ns
module sdc_bank_ctrl (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  sdc_bank_if.banks bif
);
  import sdc_pkg::*;

  for (genvar g = 0; g < BANKS; g++) begin : g_bank
    sdc_bank_state_type state_reg;
    sdc_bank_state_type state_next;
    logic [PRE_W-1:0]   timer_reg;
    logic [PRE_W-1:0]   timer_next;
    logic [ROW_W-1:0]   row_reg;
    wire  hit   = (bif.bank == BA_W'(g));
    wire  close = bif.pre_all | (bif.pre & hit) | (bif.ap_req & (bif.ap_bank == BA_W'(g)));

    // A close to an idle bank does nothing; to a precharging bank it restarts the timer.
    always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      case (state_reg)
        BANK_IDLE: begin
          if (bif.act && hit) state_next = BANK_ACTIVE; // [RULE8]
        end
        BANK_ACTIVE: begin
          if (close) begin
            state_next = BANK_PRECHARGING;
            timer_next = PRE_LOAD; // [RULE19]
          end
        end
        BANK_PRECHARGING: begin
          if (close) timer_next = PRE_LOAD; // [RULE20]
          else if (timer_reg == '0) state_next = BANK_IDLE;
          else timer_next = timer_reg - 1'b1;
        end
        default: state_next = BANK_IDLE;
      endcase
    end

    // Row address is latched only when the bank really opens.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        state_reg <= BANK_IDLE;
        timer_reg <= '0;
        row_reg   <= '0;
      end else begin
        state_reg <= state_next;
        timer_reg <= timer_next;
        if (state_reg == BANK_IDLE && bif.act && hit) row_reg <= bif.row;
      end
    end

    assign bif.open[g]        = (state_reg == BANK_ACTIVE);
    assign bif.precharging[g] = (state_reg == BANK_PRECHARGING);
    assign bif.open_row[g]    = row_reg;

    chk_precharge_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE19]
      (state_reg == BANK_ACTIVE && close) |=> (state_reg == BANK_PRECHARGING) [*2])
      else $error("bank left precharge early");
    chk_repeat_precharge: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE20]
      (state_reg == BANK_PRECHARGING && close) |=> timer_reg == PRE_LOAD)
      else $error("repeated precharge did not restart timer");
  end
endmodule

/* src/sdc_bank_if.sv */
// Carrier between the command decoder and the per-bank row tracker.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface sdc_bank_if;
  import sdc_pkg::*;
  logic                 act;
  logic                 pre;
  logic                 pre_all;
  logic [BA_W-1:0]      bank;
  logic [ROW_W-1:0]     row;
  logic                 ap_req;
  logic [BA_W-1:0]      ap_bank;
  logic [BANKS-1:0]     open;
  logic [BANKS-1:0]     precharging;
  logic [ROW_W-1:0]     open_row [BANKS];
  modport ctrl  (output act, pre, pre_all, bank, row, ap_req, ap_bank,
                 input open, precharging, open_row);
  modport banks (input act, pre, pre_all, bank, row, ap_req, ap_bank,
                 output open, precharging, open_row);
endinterface

/* src/sdc_cal_engine.sv */
// Impedance calibration engine: steps working codes toward comparator targets
// and transfers them to the I/O codes at the end of the window.
// Assumes target codes come from logic on the same clock.
`timescale 1ns/1ns
module sdc_cal_engine (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      start_i,
  input  wire logic                      long_i,
  input  wire logic [sdc_pkg::IMP_W-1:0] drive_target_i,
  input  wire logic [sdc_pkg::IMP_W-1:0] term_target_i,
  output logic                           busy_o,
  output logic [sdc_pkg::IMP_W-1:0]      drive_imp_o,
  output logic [sdc_pkg::IMP_W-1:0]      term_imp_o
);
  import sdc_pkg::*;

  logic              init_done_reg;
  logic [CAL_W-1:0]  win_reg;
  logic [STEP_W-1:0] step_reg;
  logic [IMP_W-1:0]  drv_work_reg;
  logic [IMP_W-1:0]  trm_work_reg;

  // One code step per interval, so a short window moves each code a few steps.
  function automatic logic [IMP_W-1:0] sdc_step_toward(input logic [IMP_W-1:0] cur,
                                                       input logic [IMP_W-1:0] tgt);
    if (cur < tgt) return cur + 1'b1;
    if (cur > tgt) return cur - 1'b1;
    return cur;
  endfunction

  wire              take     = start_i & ~busy_o;
  wire              step_now = busy_o & (step_reg == '0);
  wire [CAL_W-1:0]  win_load = !long_i ? SHORT_LOAD : (init_done_reg ? OPER_LOAD : INIT_LOAD);

  // A start while busy is ignored; the I/O codes change only at window end.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o        <= 1'b0;
      init_done_reg <= 1'b0;
      win_reg       <= '0;
      step_reg      <= '0;
      drv_work_reg  <= IMP_RESET;
      trm_work_reg  <= IMP_RESET;
      drive_imp_o   <= IMP_RESET;
      term_imp_o    <= IMP_RESET;
    end else if (take) begin
      busy_o   <= 1'b1;
      win_reg  <= win_load; // [RULE7]
      step_reg <= STEP_LOAD;
      if (long_i) init_done_reg <= 1'b1;
    end else if (busy_o) begin
      win_reg  <= win_reg - 1'b1;
      step_reg <= step_now ? STEP_LOAD : step_reg - 1'b1;
      if (step_now) begin
        drv_work_reg <= sdc_step_toward(drv_work_reg, drive_target_i); // [RULE6]
        trm_work_reg <= sdc_step_toward(trm_work_reg, term_target_i);
      end
      if (win_reg == '0) begin
        busy_o      <= 1'b0;
        drive_imp_o <= drv_work_reg; // [RULE4]
        term_imp_o  <= trm_work_reg;
      end
    end
  end

  chk_short_window: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE6]
    (take && !long_i) |-> ##64 busy_o ##1 !busy_o)
    else $error("short calibration window is not 64 cycles");
  chk_long_runs: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE4]
    (take && long_i) |=> busy_o [*8])
    else $error("long calibration ended too soon");
  cov_long_cal: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) take && long_i);
endmodule

/* src/sdc_cmd_decode.sv */
// Command decoder, burst sequencer and refresh timer for an eight-bank DRAM.
// Assumes the controller drives pins synchronous to ref_clk_i, one beat per clock.
// Functional notes
// [RULE1] Each command decodes from select, strobes, write enable and clock enable at an edge.
// [RULE2] Deselect takes no new command; running operations carry on.
// [RULE3] No-operation registers nothing and leaves running operations alone.
// [RULE4] Long calibration runs the engine, then updates drive and termination codes.
// [RULE5] Controller waits the init window after the first long calibration, else shorter.
// [RULE6] Short calibration corrects a small error within 64 clock cycles.
// [RULE7] Auto-precharge bit high selects long calibration, low selects short.
// [RULE8] Activate opens the addressed row in the addressed bank until precharged.
// [RULE9] Controller precharges a bank before opening another row there.
// [RULE10] Low column bits give the burst start, ordered by length and type.
// [RULE11] Auto-precharge bit high closes the row after the burst ends.
// [RULE12] With on-the-fly enabled, burst-chop bit low gives four beats, high eight.
// [RULE13] A started burst always runs to its end.
// [RULE14] Read and write codes differ only in write enable; clock enable high.
// [RULE15] A write stores its burst into the open row of the addressed bank.
// [RULE16] A byte is stored only when its data mask is low.
// [RULE17] Precharge closes one bank, or all banks when the auto-precharge bit is high.
// [RULE18] Other banks accept reads and writes during an automatic close.
// [RULE19] A closed bank reopens only after the precharge time; access needs activate.
// [RULE20] Precharge of an idle or closing bank is no-operation but restarts timing.
// [RULE21] Refresh uses an internal row counter, one row per command.
// [RULE22] Controller refreshes every 7.8 us on average, or 3.9 us when hot.
// [RULE23] Controller may postpone up to eight refreshes, nine intervals at most.
// [RULE24] A refresh lasts the refresh cycle time from the command edge.
// [RULE25] Controller keeps clock enable high and closes all banks before refresh.
// [RULE26] Reads and writes are taken only for banks holding an open row.
`timescale 1ns/1ns
module sdc_cmd_decode (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       cke_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       ras_n_i,
  input  wire logic                       cas_n_i,
  input  wire logic                       we_n_i,
  input  wire logic [sdc_pkg::BA_W-1:0]   ba_i,
  input  wire logic [sdc_pkg::ROW_W-1:0]  addr_i,
  input  wire logic                       otf_enable_i,
  input  wire logic                       fixed_chop_i,
  input  wire logic                       interleave_i,
  input  wire logic [sdc_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                       data_mask_i,
  input  wire logic [sdc_pkg::IMP_W-1:0]  drive_target_i,
  input  wire logic [sdc_pkg::IMP_W-1:0]  term_target_i,
  output logic                            mem_en_o,
  output logic                            mem_we_o,
  output logic                            mem_byte_en_o,
  output logic [sdc_pkg::BA_W-1:0]        mem_bank_o,
  output logic [sdc_pkg::ROW_W-1:0]       mem_row_o,
  output logic [sdc_pkg::COL_W-1:0]       mem_col_o,
  output logic [sdc_pkg::DATA_W-1:0]      mem_wdata_o,
  output logic                            burst_busy_o,
  output logic                            burst_chop_o,
  output logic                            refresh_busy_o,
  output logic [sdc_pkg::ROW_W-1:0]       refresh_row_o,
  output logic                            cal_busy_o,
  output logic [sdc_pkg::IMP_W-1:0]       drive_impedance_o,
  output logic [sdc_pkg::IMP_W-1:0]       termination_impedance_o,
  output logic [sdc_pkg::BANKS-1:0]       bank_open_o,
  output logic [sdc_pkg::BANKS-1:0]       bank_precharging_o,
  output logic                            cmd_reject_o
);
  import sdc_pkg::*;

  sdc_bank_if bif ();

  logic              busy_reg;
  logic [2:0]        beat_reg;
  logic              write_reg;
  logic              ap_reg;
  logic              chop_reg;
  logic              interleave_reg;
  logic [BA_W-1:0]   bank_reg;
  logic [ROW_W-1:0]  row_reg;
  logic [COL_W-1:0]  col_reg;
  logic [REF_W-1:0]  ref_timer_reg;
  logic [REF_W:0]    ref_age_reg;

  // Command decode from the pin levels at this edge.
  sdc_cmd_type cmd;
  assign cmd = sdc_decode(cke_i, cs_n_i, {ras_n_i, cas_n_i, we_n_i}); // [RULE1] [RULE14]

  wire all_idle  = ~|(bif.open | bif.precharging);
  wire bank_idle = !bif.open[ba_i] && !bif.precharging[ba_i];
  wire rw_cmd    = (cmd == CMD_READ) || (cmd == CMD_WRITE);
  wire chop_sel  = otf_enable_i ? !addr_i[ADDR_BURST_CHOP_BIT] : fixed_chop_i; // [RULE12]

  // Acceptance: a burst cannot be cut short, so a second access before its end is refused.
  wire rw_take  = rw_cmd && bif.open[ba_i] && !busy_reg; // [RULE26] [RULE13] [RULE18]
  wire act_take = (cmd == CMD_ACTIVATE) && bank_idle && !refresh_busy_o; // [RULE19] [RULE9]
  wire pre_cmd  = (cmd == CMD_PRECHARGE);
  wire ref_take = (cmd == CMD_REFRESH) && all_idle && !refresh_busy_o && !busy_reg; // [RULE25]
  wire cal_take = (cmd == CMD_CALIBRATE);
  wire reject   = (rw_cmd && !rw_take) || ((cmd == CMD_ACTIVATE) && !act_take)
                || ((cmd == CMD_REFRESH) && !ref_take);

  // Burst end and the automatic close that may follow it.
  wire last_beat = (beat_reg == (chop_reg ? CHOP_LAST : EIGHT_LAST));
  wire ap_fire   = busy_reg && last_beat && ap_reg; // [RULE11]

  // Requests to the bank tracker; automatic close travels on its own lane.
  assign bif.act     = act_take; // [RULE8]
  assign bif.pre     = pre_cmd && !addr_i[ADDR_AUTO_PRECHARGE_BIT]; // [RULE17]
  assign bif.pre_all = pre_cmd && addr_i[ADDR_AUTO_PRECHARGE_BIT]; // [RULE17]
  assign bif.bank    = ba_i;
  assign bif.row     = addr_i;
  assign bif.ap_req  = ap_fire;
  assign bif.ap_bank = bank_reg;

  // Column of the current beat: wrap inside the four or eight column block.
  wire [2:0] beat_off = interleave_reg ? (col_reg[2:0] ^ beat_reg)
                                       : (col_reg[2:0] + beat_reg); // [RULE10]
  wire [COL_W-1:0] beat_col = chop_reg ? {col_reg[COL_W-1:2], beat_off[1:0]}
                                       : {col_reg[COL_W-1:3], beat_off};

  sdc_bank_ctrl u_banks (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .bif       (bif)
  );

  sdc_cal_engine u_cal (
    .ref_clk_i      (ref_clk_i),
    .rst_n_i        (rst_n_i),
    .start_i        (cal_take),
    .long_i         (addr_i[ADDR_AUTO_PRECHARGE_BIT]),
    .drive_target_i (drive_target_i),
    .term_target_i  (term_target_i),
    .busy_o         (cal_busy_o),
    .drive_imp_o    (drive_impedance_o),
    .term_imp_o     (termination_impedance_o)
  );

  // Burst sequencer: deselect and no-operation fall through and leave it running.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg       <= 1'b0;
      beat_reg       <= '0;
      write_reg      <= 1'b0;
      ap_reg         <= 1'b0;
      chop_reg       <= 1'b0;
      interleave_reg <= 1'b0;
      bank_reg       <= '0;
      row_reg        <= '0;
      col_reg        <= '0;
    end else if (rw_take) begin
      busy_reg       <= 1'b1;
      beat_reg       <= '0;
      write_reg      <= (cmd == CMD_WRITE);
      ap_reg         <= addr_i[ADDR_AUTO_PRECHARGE_BIT]; // [RULE11]
      chop_reg       <= chop_sel; // [RULE12]
      interleave_reg <= interleave_i;
      bank_reg       <= ba_i; // [RULE15]
      row_reg        <= bif.open_row[ba_i];
      col_reg        <= addr_i[COL_W-1:0]; // [RULE10]
    end else if (busy_reg) begin
      beat_reg <= beat_reg + 1'b1;
      if (last_beat) busy_reg <= 1'b0; // [RULE13]
    end
  end

  // Array port: one beat per clock, write data and mask sampled with the beat.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_en_o      <= 1'b0;
      mem_we_o      <= 1'b0;
      mem_byte_en_o <= 1'b0;
      mem_bank_o    <= '0;
      mem_row_o     <= '0;
      mem_col_o     <= '0;
      mem_wdata_o   <= '0;
    end else begin
      mem_en_o      <= busy_reg;
      mem_we_o      <= busy_reg && write_reg; // [RULE15]
      mem_byte_en_o <= busy_reg && (!write_reg || !data_mask_i); // [RULE16]
      mem_bank_o    <= bank_reg;
      mem_row_o     <= row_reg;
      mem_col_o     <= beat_col;
      mem_wdata_o   <= wr_data_i;
    end
  end

  // Refresh timer and internal row counter; address pins play no part.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      refresh_busy_o <= 1'b0;
      ref_timer_reg  <= '0;
      refresh_row_o  <= '0;
    end else if (ref_take) begin
      refresh_busy_o <= 1'b1; // [RULE24]
      ref_timer_reg  <= REF_LOAD;
      refresh_row_o  <= refresh_row_o + 1'b1; // [RULE21]
    end else if (refresh_busy_o) begin
      ref_timer_reg <= ref_timer_reg - 1'b1;
      if (ref_timer_reg == '0) refresh_busy_o <= 1'b0;
    end
  end

  // Status copies; they trail the bank tracker, burst sequencer and decode by one clock.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_open_o        <= '0;
      bank_precharging_o <= '0;
      burst_busy_o       <= 1'b0;
      burst_chop_o       <= 1'b0;
      cmd_reject_o       <= 1'b0;
    end else begin
      bank_open_o        <= bif.open;
      bank_precharging_o <= bif.precharging;
      burst_busy_o       <= busy_reg;
      burst_chop_o       <= chop_reg;
      cmd_reject_o       <= reject;
    end
  end

  // Helper for the refresh length check: counts cycles of the current refresh.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ref_age_reg <= '0;
    else if (ref_take) ref_age_reg <= '0;
    else if (refresh_busy_o) ref_age_reg <= ref_age_reg + 1'b1;
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_read_code: assert property ( // [RULE14]
    (cke_i && !cs_n_i && ras_n_i && !cas_n_i && we_n_i) |-> cmd == CMD_READ)
    else $error("read pattern not decoded as read");
  chk_deselect_quiet: assert property ( // [RULE2]
    (cs_n_i && !busy_reg) |=> !busy_reg)
    else $error("deselect started a burst");
  chk_nop_keeps_burst: assert property ( // [RULE3]
    (cmd == CMD_NOP && busy_reg && !last_beat) |=> busy_reg)
    else $error("no-operation disturbed a burst");
  chk_rw_needs_open: assert property ( // [RULE26]
    (rw_cmd && !bif.open[ba_i]) |=> cmd_reject_o)
    else $error("access to a bank without open row not refused");
  chk_burst_eight: assert property ( // [RULE12] [RULE13]
    (rw_take && !chop_sel) |=> busy_reg [*8] ##1 !busy_reg)
    else $error("eight-beat burst length wrong");
  chk_burst_chop: assert property ( // [RULE12]
    (rw_take && chop_sel) |=> busy_reg [*4] ##1 !busy_reg)
    else $error("chopped burst length wrong");
  chk_mask_blocks: assert property ( // [RULE16]
    $past(busy_reg && write_reg) |-> mem_byte_en_o == !$past(data_mask_i))
    else $error("masked byte was written");
  chk_autoclose_fires: assert property ( // [RULE11]
    ap_fire |=> bif.precharging[$past(bank_reg)])
    else $error("auto precharge did not close the bank");
  chk_activate_opens: assert property ( // [RULE8]
    act_take |=> bif.open[$past(ba_i)])
    else $error("activate did not open the bank");
  chk_pre_all_closes: assert property ( // [RULE17]
    (pre_cmd && addr_i[ADDR_AUTO_PRECHARGE_BIT]) |=> bif.open == '0)
    else $error("precharge all left a bank open");
  chk_refresh_length: assert property ( // [RULE24]
    $fell(refresh_busy_o) |-> ref_age_reg == (REF_W+1)'(REFRESH_CYCLES))
    else $error("refresh period length wrong");
  chk_refresh_row: assert property ( // [RULE21]
    ref_take |=> refresh_row_o == $past(refresh_row_o) + 1'b1)
    else $error("refresh row did not advance");

  cov_read_burst:  cover property (rw_take && cmd == CMD_READ);
  cov_write_close: cover property (rw_take && cmd == CMD_WRITE && addr_i[ADDR_AUTO_PRECHARGE_BIT]);
  cov_refresh:     cover property (ref_take);
endmodule

/* src/sdc_pkg.sv */
// Shared constants, enumerations and the command decode function for the
// command decoder and bank tracker. Assumes a 100 MHz core clock.
package sdc_pkg;
  localparam int BANKS  = 8;
  localparam int BA_W   = 3;
  localparam int ROW_W  = 14;
  localparam int COL_W  = 10;
  localparam int DATA_W = 8;
  localparam int IMP_W  = 4;
  localparam int ADDR_AUTO_PRECHARGE_BIT = 10;
  localparam int ADDR_BURST_CHOP_BIT     = 12;

  // Clock rate and timing figures; precharge and refresh cycle counts derive from them.
  localparam int CLK_PERIOD_NS          = 10;
  localparam int PRECHARGE_TIME_NS      = 15;
  localparam int REFRESH_CYCLE_TIME_NS  = 160;
  localparam int PRECHARGE_CYCLES = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLES   = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CAL_CYCLES  = 512;
  localparam int OPER_CAL_CYCLES  = 256;
  localparam int SHORT_CAL_CYCLES = 64;
  localparam int CAL_STEP_CYCLES  = 16;
  localparam int PRE_W = 4;
  localparam int REF_W = 8;
  localparam int CAL_W = 10;
  localparam int STEP_W = 4;
  localparam logic [PRE_W-1:0]  PRE_LOAD   = PRE_W'(PRECHARGE_CYCLES - 1);
  localparam logic [REF_W-1:0]  REF_LOAD   = REF_W'(REFRESH_CYCLES - 1);
  localparam logic [CAL_W-1:0]  INIT_LOAD  = CAL_W'(INIT_CAL_CYCLES - 1);
  localparam logic [CAL_W-1:0]  OPER_LOAD  = CAL_W'(OPER_CAL_CYCLES - 1);
  localparam logic [CAL_W-1:0]  SHORT_LOAD = CAL_W'(SHORT_CAL_CYCLES - 1);
  localparam logic [STEP_W-1:0] STEP_LOAD  = STEP_W'(CAL_STEP_CYCLES - 1);
  localparam logic [2:0] CHOP_LAST  = 3'h3;
  localparam logic [2:0] EIGHT_LAST = 3'h7;
  localparam logic [IMP_W-1:0] IMP_RESET = 4'h8;

  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_REFRESH, CMD_CALIBRATE, CMD_OTHER
  } sdc_cmd_type;

  typedef enum logic [1:0] {BANK_IDLE, BANK_ACTIVE, BANK_PRECHARGING} sdc_bank_state_type;

  // Clock enable low means no command here; power-down lies outside this block.
  function automatic sdc_cmd_type sdc_decode(input logic cke, input logic cs_n,
                                             input logic [2:0] rcw_n);
    if (!cke) return CMD_NOP;
    if (cs_n) return CMD_DESELECT;
    case (rcw_n)
      3'h7:    return CMD_NOP;
      3'h3:    return CMD_ACTIVATE;
      3'h5:    return CMD_READ;
      3'h4:    return CMD_WRITE;
      3'h2:    return CMD_PRECHARGE;
      3'h1:    return CMD_REFRESH;
      3'h6:    return CMD_CALIBRATE;
      default: return CMD_OTHER;
    endcase
  endfunction
endpackage

/* test/sdc_cmd_decode_tb_top.sv */
// Self-checking bench: bursts, bank state, refresh and calibration of the decoder.
// Assumes the controller model drives the command pins; data and mask come from here.
`timescale 1ns/1ns
module sdc_cmd_decode_tb_top;
  import sdc_pkg::*;
  localparam logic [ROW_W-1:0] ROW_A = 14'h0123;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [DATA_W-1:0] wr_data_i = '0;
  logic data_mask_i = 1'b0;
  logic interleave_i = 1'b0;
  logic otf_enable_i = 1'b1;
  wire  cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, mem_en_o, mem_we_o, mem_byte_en_o;
  wire  burst_busy_o, burst_chop_o, refresh_busy_o, cal_busy_o, cmd_reject_o;
  wire  [BA_W-1:0] ba_i, mem_bank_o;
  wire  [ROW_W-1:0] addr_i, mem_row_o, refresh_row_o;
  wire  [COL_W-1:0] mem_col_o;
  wire  [DATA_W-1:0] mem_wdata_o;
  wire  [IMP_W-1:0] drive_impedance_o, termination_impedance_o;
  wire  [BANKS-1:0] bank_open_o, bank_precharging_o;
  int   num_errors = 0;
  int   samples_checked = 0;
  int   rejects = 0;
  sdc_cmd_decode sdc_cmd_decode_i (.ref_clk_i, .rst_n_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i,
    .we_n_i, .ba_i, .addr_i, .otf_enable_i, .fixed_chop_i(1'b1), .interleave_i,
    .wr_data_i, .data_mask_i, .drive_target_i(4'ha), .term_target_i(4'h6), .mem_en_o,
    .mem_we_o, .mem_byte_en_o, .mem_bank_o, .mem_row_o, .mem_col_o, .mem_wdata_o,
    .burst_busy_o, .burst_chop_o, .refresh_busy_o, .refresh_row_o, .cal_busy_o,
    .drive_impedance_o, .termination_impedance_o, .bank_open_o, .bank_precharging_o,
    .cmd_reject_o);
  sdc_ctrl_model sdc_ctrl_model_i (.ref_clk_i, .cke_o(cke_i), .cs_n_o(cs_n_i),
    .rcw_n_o({ras_n_i, cas_n_i, we_n_i}), .ba_o(ba_i), .addr_o(addr_i));
  // Clock; refusals are counted so checks need not know the pulse cycle exactly.
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (cmd_reject_o === 1'b1) rejects++;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [2:0] rcw, input logic [BA_W-1:0] ba, input logic [ROW_W-1:0] a);
    sdc_ctrl_model_i.issue(1'b0, rcw, ba, a);
  endtask
  task automatic wait_chk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // One burst to bank 2: a write gets a read thrown at it mid-burst, which must be refused.
  task automatic burst(input logic wr, input logic [ROW_W-1:0] a, input int n);
    logic [COL_W-1:0] c;
    logic [2:0]       o;
    cmd({2'b10, ~wr}, 3'h2, a);
    fork
      for (int k = 0; k < n; k++) begin
        wr_data_i   <= 8'ha0 + 8'(k);
        data_mask_i <= k[0];
        @(posedge ref_clk_i);
      end
      for (int k = 0; k < n; k++) begin
        wait_chk(1);
        o = interleave_i ? a[2:0] ^ 3'(k) : a[2:0] + 3'(k);
        c = (n == 8) ? {a[9:3], o} : {a[9:2], o[1:0]};
        chk("beat col", 16'(c), 16'(mem_col_o));
        chk("beat we en", 16'({wr, 2'h3}), 16'({mem_we_o, mem_en_o, burst_busy_o}));
        chk("byte en", 16'(wr ? !k[0] : 1'b1), 16'(mem_byte_en_o));
        chk("chop", 16'(n == 4), 16'(burst_chop_o));
        chk("bank", 16'h2, 16'(mem_bank_o));
        chk("row", 16'(ROW_A), 16'(mem_row_o));
        if (wr) chk("wdata", 16'(8'ha0 + 8'(k)), 16'(mem_wdata_o));
      end
      if (wr) cmd(3'h5, 3'h2, a);
    join
    wait_chk(1);
    chk("burst end", 16'h0, 16'({mem_en_o, burst_busy_o}));
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence of tests.
  initial begin
    repeat (10) @(posedge ref_clk_i);
    chk("reset codes", 16'h0088, 16'({drive_impedance_o, termination_impedance_o}));
    rst_n_i <= 1'b1;
    cmd(3'h1, 3'h0, 14'h0);
    wait_chk(0);
    chk("refresh row", 16'h0001, 16'(refresh_row_o));
    wait_chk(15);
    chk("refresh busy", 16'h1, 16'(refresh_busy_o));
    wait_chk(1);
    chk("refresh end", 16'h0, 16'(refresh_busy_o));
    $display("refresh test done");
    sdc_ctrl_model_i.issue(1'b1, 3'h5, 3'h1, 14'h0);
    cmd(3'h5, 3'h1, 14'h0);
    wait_chk(3);
    chk("rejects", 16'h1, 16'(rejects));
    cmd(3'h3, 3'h2, ROW_A);
    wait_chk(2);
    chk("open", 16'h0004, 16'(bank_open_o));
    burst(1'b1, 14'h1005, 8);
    chk("row kept", 16'h0004, 16'(bank_open_o));
    chk("mid read", 16'h2, 16'(rejects));
    @(posedge ref_clk_i);
    interleave_i <= 1'b1;
    otf_enable_i <= 1'b0;
    burst(1'b0, 14'h1405, 4);
    wait_chk(6);
    chk("auto close", 16'h0, 16'({bank_open_o, bank_precharging_o}));
    $display("burst test done");
    cmd(3'h3, 3'h3, ROW_A);
    cmd(3'h3, 3'h4, ROW_A);
    cmd(3'h2, 3'h3, 14'h0);
    cmd(3'h2, 3'h3, 14'h0);
    wait_chk(1);
    chk("one closing", 16'h1008, 16'({bank_open_o, bank_precharging_o}));
    cmd(3'h2, 3'h0, 14'h0400);
    wait_chk(4);
    chk("all closed", 16'h0, 16'({bank_open_o, bank_precharging_o}));
    $display("precharge test done");
    cmd(3'h6, 3'h0, 14'h0400);
    wait_chk(300);
    chk("long cal", 16'h1, 16'(cal_busy_o));
    wait_chk(220);
    chk("cal codes", 16'h00a6,
        16'({cal_busy_o, drive_impedance_o, termination_impedance_o}));
    cmd(3'h6, 3'h0, 14'h0);
    wait_chk(0);
    chk("short cal", 16'h1, 16'(cal_busy_o));
    wait_chk(70);
    chk("short end", 16'h0, 16'(cal_busy_o));
    $display("calibration test done");
    wrap_up();
  end
  // Watchdog: the run needs about 700 cycles, so 5,000 means a hang.
  initial begin
    #50000;
    num_errors++;
    wrap_up();
  end
endmodule

/* test/sdc_ctrl_model.sv */
// Memory controller model: drives clock enable, select, strobes, bank and address.
// Assumes the design clock; pins change by non-blocking assignment at an edge.
`timescale 1ns/1ns
module sdc_ctrl_model (
  input  wire logic                 ref_clk_i,
  output logic                      cke_o,
  output logic                      cs_n_o,
  output logic [2:0]                rcw_n_o,
  output logic [sdc_pkg::BA_W-1:0]  ba_o,
  output logic [sdc_pkg::ROW_W-1:0] addr_o
);
  import sdc_pkg::*;
  // Rests as a selected no-op with clock enable high throughout.
  initial begin
    cke_o   = 1'b1;
    cs_n_o  = 1'b0;
    rcw_n_o = 3'h7;
    ba_o    = '0;
    addr_o  = '0;
  end
  // One command for one edge; the address then shows its inverse, never a stale copy.
  task automatic issue(input logic cs_n, input logic [2:0] rcw, input logic [BA_W-1:0] ba,
                       input logic [ROW_W-1:0] a);
    @(posedge ref_clk_i);
    cs_n_o  <= cs_n;
    rcw_n_o <= rcw;
    ba_o    <= ba;
    addr_o  <= a;
    @(posedge ref_clk_i);
    cs_n_o  <= 1'b0;
    rcw_n_o <= 3'h7;
    addr_o  <= ~a;
  endtask
endmodule
